//--- mpm_phy.sv
// phy-side model: link clocks, receive frames, transmit capture, mdio pull-up
// assumes the port drives tx on rising tx clock edges
`timescale 1ns/1ps
`default_nettype none
module mpm_phy
  import mpm_pkg::*;
(
  output logic o_tx_clk,
  output logic o_rx_clk,
  output logic o_rx_dv,
  output logic [NIBBLE_W-1:0] o_rxd,
  output logic o_mdio_i,
  input wire logic i_tx_en,
  input wire logic [NIBBLE_W-1:0] i_txd,
  input wire logic i_mdio_o,
  input wire logic i_mdio_oe
);
  logic [NIBBLE_W-1:0] tx_q[$];
  // *******************************
  // free-running clocks, unrelated phases
  // *******************************
  initial begin
    o_tx_clk = 1'b0;
    #3.1;
    forever #7.5 o_tx_clk = ~o_tx_clk;
  end
  initial begin
    o_rx_clk = 1'b0;
    o_rx_dv = 1'b0;
    o_rxd = 4'hF;
    #1.7;
    forever #7.5 o_rx_clk = ~o_rx_clk;
  end
  // released mdio floats up through the pull-up
  assign o_mdio_i = i_mdio_oe ? i_mdio_o : 1'b1;
  // take one nibble for every enabled tx period
  always @(posedge o_tx_clk) begin
    if (i_tx_en === 1'b1) tx_q.push_back(i_txd);
  end
  // receive frame, no error line exists
  task automatic rx_frame(input int len, input logic [NIBBLE_W-1:0] base);
    for (int k = 0; k < len; k++) begin
      @(negedge o_rx_clk);
      o_rx_dv = 1'b1;
      o_rxd = base + 4'(k);
    end
    @(negedge o_rx_clk);
    o_rx_dv = 1'b0;
    o_rxd = ~o_rxd; // stale data must not look valid
  endtask
endmodule
`default_nettype wire

//--- mpm_pkg.sv
// constants shared by the mii port and its synchronisers
// assumes a 200 MHz core clock and phy-made transmit and receive clocks
package mpm_pkg;

  // ****************************************
  // widths and synchroniser depth
  // ****************************************
  localparam int NIBBLE_W = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [NIBBLE_W-1:0] NIBBLE_RST = 4'h0;

  // ****************************************
  // management clock timing
  // ****************************************
  localparam int CORE_CLK_KHZ = 200000;
  localparam int MDC_MAX_KHZ = 2500;
  // least core cycles per management clock half period, rounded up
  localparam int MDC_HALF_CYC = (CORE_CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam int MDC_CNT_W = 8;

  // ****************************************
  // transmit states, gray along idle-send-drop
  // ****************************************
  typedef enum logic [1:0] {
    MPM_TX_IDLE = 2'h0,
    MPM_TX_SEND = 2'h1,
    MPM_TX_DROP = 2'h3
  } mpm_tx_state_e;

endpackage

//--- mpm_port.sv
// mii port toward an external phy, with software-timed station management
// assumes: core clock 200 MHz with synchronous active-low reset; phy supplies
// free-running transmit and receive clocks; mdc and mdio pins levels are set by
// the core-side control bits, mdio resolved outside from o_mdio_o and o_mdio_oe
`timescale 1ns/1ps
`default_nettype none
module mpm_port (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_mdc_bit,
  input wire logic i_mdio_out_bit,
  input wire logic i_mdio_oe_bit,
  output logic o_mdio_in_bit,
  output logic o_mdio_rise_bit,
  output logic o_mdc_fast,
  output logic o_crs,
  output logic o_col,
  output logic o_mdc,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic i_mdio_i,
  input wire logic i_crs,
  input wire logic i_col,
  input wire logic i_tx_clk,
  input wire logic i_tx_valid,
  input wire logic [mpm_pkg::NIBBLE_W-1:0] i_tx_nibble,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  output logic o_tx_abort,
  output logic o_tx_en,
  output logic [mpm_pkg::NIBBLE_W-1:0] o_txd,
  input wire logic i_rx_clk,
  input wire logic i_rx_dv,
  input wire logic [mpm_pkg::NIBBLE_W-1:0] i_rxd,
  output logic o_rx_valid,
  output logic [mpm_pkg::NIBBLE_W-1:0] o_rx_nibble,
  output logic o_rx_end
);
  import mpm_pkg::*;

  // ****************************************
  // core domain: station management pins
  // ****************************************
  logic mdio_s;
  logic mdc_q;
  logic [MDC_CNT_W-1:0] mdc_cnt;
  logic [1:0] core_link_s;
  wire mdc_rise = o_mdc & ~mdc_q;
  wire mdc_edge = o_mdc ^ mdc_q;
  wire mdc_short = mdc_cnt < MDC_CNT_W'(MDC_HALF_CYC);

  // pin level only reaches logic after two flops
  mpm_sync #(.WIDTH(1)) u_mdio_sync (
    .i_clk(i_core_clk),
    .i_async(i_mdio_i),
    .o_sync(mdio_s)
  );

  // carrier and collision as status levels in the core
  mpm_sync #(.WIDTH(2)) u_core_link_sync (
    .i_clk(i_core_clk),
    .i_async({i_crs, i_col}),
    .o_sync(core_link_s)
  );

  // pins follow the control bits one cycle later, no clock generator
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_mdc <= 1'b0;
      o_mdio_o <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else begin
      o_mdc <= i_mdc_bit;
      o_mdio_o <= i_mdio_out_bit;
      o_mdio_oe <= i_mdio_oe_bit;
    end
  end

  // sampled mdio, plus a copy frozen at each mdc rise for read-back
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      mdc_q <= 1'b0;
      o_mdio_in_bit <= 1'b0;
      o_mdio_rise_bit <= 1'b0;
      o_crs <= 1'b0;
      o_col <= 1'b0;
    end else begin
      mdc_q <= o_mdc;
      o_mdio_in_bit <= mdio_s;
      o_crs <= core_link_s[1];
      o_col <= core_link_s[0];
      if (mdc_rise) begin
        o_mdio_rise_bit <= mdio_s;
      end
    end
  end

  // half-period watch: flags an mdc level held shorter than the 2.5 MHz limit;
  // a flag only, since many phys accept a faster clock
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      mdc_cnt <= MDC_CNT_W'(MDC_HALF_CYC); // no false flag on the first edge after reset
      o_mdc_fast <= 1'b0;
    end else begin
      o_mdc_fast <= mdc_edge & mdc_short;
      if (mdc_edge) begin
        mdc_cnt <= MDC_CNT_W'(1);
      end else if (mdc_short) begin
        mdc_cnt <= mdc_cnt + MDC_CNT_W'(1);
      end
    end
  end

  AST_MDC_FOLLOW: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    1'b1 |=> o_mdc == $past(i_mdc_bit)) else $error("mdc does not follow its bit");
  AST_MDIO_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ##1 (o_mdio_oe == $past(i_mdio_oe_bit)) && (o_mdio_o == $past(i_mdio_out_bit)))
    else $error("mdio drive lags its bits");
  AST_MDIO_RISE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    mdc_rise |=> o_mdio_rise_bit == $past(mdio_s)) else $error("mdio not caught at mdc rise");

  // ****************************************
  // transmit domain on the phy transmit clock
  // ****************************************
  logic tx_nrst;
  logic [1:0] tx_link_s;
  mpm_tx_state_e tx_state;
  mpm_tx_state_e next_tx_state;
  wire tx_crs = tx_link_s[1];
  wire tx_col = tx_link_s[0];

  // reset and medium status cross in through two flops each
  mpm_sync #(.WIDTH(1)) u_tx_rst_sync (
    .i_clk(i_tx_clk),
    .i_async(i_nrst),
    .o_sync(tx_nrst)
  );
  mpm_sync #(.WIDTH(2)) u_tx_link_sync (
    .i_clk(i_tx_clk),
    .i_async({i_crs, i_col}),
    .o_sync(tx_link_s)
  );

  // defer the frame start while the medium is busy; once started, take every cycle
  assign o_tx_ready = tx_nrst & ((tx_state != MPM_TX_IDLE) | ~tx_crs);
  wire tx_take = i_tx_valid & o_tx_ready;
  wire tx_hit = (tx_state == MPM_TX_SEND) & tx_col;
  wire tx_send = tx_take & (tx_state != MPM_TX_DROP) & ~tx_hit;

  // collision drops the rest of the frame up to its last nibble;
  // a gap in valid mid-frame ends the frame, there is no buffer to ride it out
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      MPM_TX_IDLE: begin
        if (tx_take && !i_tx_last) begin
          next_tx_state = MPM_TX_SEND;
        end
      end
      MPM_TX_SEND: begin
        if (!i_tx_valid || i_tx_last) begin
          next_tx_state = MPM_TX_IDLE;
        end else if (tx_hit) begin
          next_tx_state = MPM_TX_DROP;
        end
      end
      MPM_TX_DROP: begin
        // a gap ends a dropped frame too, so a stopped source cannot wedge the port
        if (!i_tx_valid || i_tx_last) begin
          next_tx_state = MPM_TX_IDLE;
        end
      end
      default: next_tx_state = MPM_TX_IDLE;
    endcase
  end

  // enable and nibble launched on the rising tx clock edge
  always_ff @(posedge i_tx_clk) begin
    if (!tx_nrst) begin
      tx_state <= MPM_TX_IDLE;
      o_tx_en <= 1'b0;
      o_txd <= NIBBLE_RST;
      o_tx_abort <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      o_tx_en <= tx_send;
      o_tx_abort <= tx_hit;
      if (tx_send) begin
        o_txd <= i_tx_nibble;
      end
    end
  end

  AST_TX_NIBBLE: assert property (@(posedge i_tx_clk) disable iff (!tx_nrst)
    tx_send |=> o_tx_en && (o_txd == $past(i_tx_nibble))) else $error("nibble not launched");
  AST_TX_QUIET: assert property (@(posedge i_tx_clk) disable iff (!tx_nrst)
    !tx_send |=> !o_tx_en) else $error("tx enable without a nibble");
  AST_TX_DEFER: assert property (@(posedge i_tx_clk) disable iff (!tx_nrst)
    (tx_state == MPM_TX_IDLE) && tx_crs |-> !o_tx_ready) else $error("start during carrier");
  AST_TX_COL: assert property (@(posedge i_tx_clk) disable iff (!tx_nrst)
    tx_hit |=> !o_tx_en && o_tx_abort ##1 !o_tx_abort) else $error("collision not handled");

  // ****************************************
  // receive domain on the phy receive clock
  // ****************************************
  logic rx_nrst;

  mpm_sync #(.WIDTH(1)) u_rx_rst_sync (
    .i_clk(i_rx_clk),
    .i_async(i_nrst),
    .o_sync(rx_nrst)
  );

  // data and valid are already on the rx clock: one plain register stage,
  // nibble held while valid is low; no error input, frame ends on valid fall
  always_ff @(posedge i_rx_clk) begin
    if (!rx_nrst) begin
      o_rx_valid <= 1'b0;
      o_rx_nibble <= NIBBLE_RST;
      o_rx_end <= 1'b0;
    end else begin
      o_rx_valid <= i_rx_dv;
      o_rx_end <= o_rx_valid & ~i_rx_dv;
      if (i_rx_dv) begin
        o_rx_nibble <= i_rxd;
      end
    end
  end

  AST_RX_TAKE: assert property (@(posedge i_rx_clk) disable iff (!rx_nrst)
    i_rx_dv |=> o_rx_valid && (o_rx_nibble == $past(i_rxd))) else $error("rx nibble lost");
  AST_RX_HOLD: assert property (@(posedge i_rx_clk) disable iff (!rx_nrst)
    !i_rx_dv |=> !o_rx_valid && $stable(o_rx_nibble)) else $error("rx taken while invalid");
  AST_RX_END: assert property (@(posedge i_rx_clk) disable iff (!rx_nrst)
    o_rx_valid && !i_rx_dv |=> o_rx_end ##1 !o_rx_end) else $error("frame end not marked");

endmodule
`default_nettype wire

//--- mpm_sync.sv
// two flip-flop level synchroniser, any width
// assumes each bit is a level that stays put for several destination edges
`timescale 1ns/1ps
`default_nettype none
module mpm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  import mpm_pkg::*;

  // ****************************************
  // stages
  // ****************************************
  logic [WIDTH-1:0] meta;

  // first stage is read by the second only
  always_ff @(posedge i_clk) begin
    meta <= i_async;
    o_sync <= meta;
  end

endmodule
`default_nettype wire

//--- tb_mii_port_with_management.sv
// bench for the mii port: management pins, carrier sync, tx and rx streams
// assumes mpm_phy supplies both link clocks and the receive frames
`timescale 1ns/1ps
`default_nettype none
module tb_mii_port_with_management;
  import mpm_pkg::*;
  logic core_clk = 1'b0;
  logic nrst, mdc_bit, mo_bit, moe_bit, crs, col, tx_valid, tx_last;
  logic mdio_in, mdio_rise, mdc_fast, crs_s, col_s, mdc, mdio_o, mdio_oe, mdio_i;
  logic tx_clk, tx_ready, tx_abort, tx_en, rx_clk, rx_dv, rx_valid, rx_end;
  logic [NIBBLE_W-1:0] tx_nib, txd, rxd, rx_nib;
  logic [NIBBLE_W-1:0] rx_q[$];
  int errors, check_count, aborts, fasts, ends;
  // *******************************
  // clock, design, phy and monitors
  // *******************************
  always #2.5 core_clk = ~core_clk;
  mpm_port i_dut (.i_core_clk(core_clk), .i_nrst(nrst), .i_mdc_bit(mdc_bit),
    .i_mdio_out_bit(mo_bit), .i_mdio_oe_bit(moe_bit), .o_mdio_in_bit(mdio_in),
    .o_mdio_rise_bit(mdio_rise), .o_mdc_fast(mdc_fast), .o_crs(crs_s), .o_col(col_s),
    .o_mdc(mdc), .o_mdio_o(mdio_o), .o_mdio_oe(mdio_oe), .i_mdio_i(mdio_i), .i_crs(crs),
    .i_col(col), .i_tx_clk(tx_clk), .i_tx_valid(tx_valid), .i_tx_nibble(tx_nib),
    .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_tx_abort(tx_abort), .o_tx_en(tx_en),
    .o_txd(txd), .i_rx_clk(rx_clk), .i_rx_dv(rx_dv), .i_rxd(rxd), .o_rx_valid(rx_valid),
    .o_rx_nibble(rx_nib), .o_rx_end(rx_end));
  mpm_phy i_phy (.o_tx_clk(tx_clk), .o_rx_clk(rx_clk), .o_rx_dv(rx_dv), .o_rxd(rxd),
    .o_mdio_i(mdio_i), .i_tx_en(tx_en), .i_txd(txd), .i_mdio_o(mdio_o), .i_mdio_oe(mdio_oe));
  // pulses counted at falling edges, where they have settled
  always @(negedge core_clk) fasts += int'(mdc_fast === 1'b1);
  always @(negedge tx_clk) aborts += int'(tx_abort === 1'b1);
  always @(negedge rx_clk) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_nib);
    ends += int'(rx_end === 1'b1);
  end
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic core(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic summarize;
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // management pins: slow clocking, then one short low level
  task automatic t_mgmt;
    fasts = 0;
    moe_bit = 1'b1;
    core(1);
    chk("mdio_oe", 4'h1, 4'(mdio_oe));
    chk("mdio_o", 4'h0, 4'(mdio_o));
    core(45);
    chk("mdio_in", 4'h0, 4'(mdio_in));
    mdc_bit = 1'b1;
    core(1);
    chk("mdc", 4'h1, 4'(mdc));
    core(2);
    chk("mdio_rise", 4'h0, 4'(mdio_rise));
    mo_bit = 1'b1;
    core(5);
    chk("mdio_o", 4'h1, 4'(mdio_o));
    chk("mdio_in", 4'h1, 4'(mdio_in));
    moe_bit = 1'b0;
    core(45);
    chk("mdio_in", 4'h1, 4'(mdio_in));
    mdc_bit = 1'b0;
    core(45);
    chk("mdc", 4'h0, 4'(mdc));
    mdc_bit = 1'b1;
    core(3);
    chk("mdio_rise", 4'h1, 4'(mdio_rise));
    chk("mdc_fast", 4'h0, 4'(fasts));
    core(45);
    mdc_bit = 1'b0;
    core(2);
    mdc_bit = 1'b1;
    core(6);
    chk("mdc_fast", 4'h1, 4'(fasts));
  endtask
  // carrier and collision sync, deferral while carrier is up
  task automatic t_crs;
    crs = 1'b1;
    col = 1'b1;
    core(4);
    chk("crs", 4'h1, 4'(crs_s));
    chk("col", 4'h1, 4'(col_s));
    repeat (5) @(negedge tx_clk);
    chk("tx_ready", 4'h0, 4'(tx_ready));
    crs = 1'b0;
    col = 1'b0;
    core(4);
    chk("crs", 4'h0, 4'(crs_s));
    chk("col", 4'h0, 4'(col_s));
    repeat (5) @(negedge tx_clk);
    chk("tx_ready", 4'h1, 4'(tx_ready));
  endtask
  // back-to-back nibbles, collision from nibble col_at when not negative
  task automatic t_tx(input int len, input int col_at);
    int w;
    i_phy.tx_q.delete();
    aborts = 0;
    for (int k = 0; k < len; k++) begin
      @(negedge tx_clk);
      col = (col_at >= 0 && k >= col_at);
      tx_valid = 1'b1;
      tx_nib = 4'h3 + 4'(k);
      tx_last = (k == len - 1);
      for (w = 0; w < 20 && tx_ready !== 1'b1; w++) @(negedge tx_clk);
      if (w == 20) begin
        errors++;
        summarize();
      end
    end
    @(negedge tx_clk);
    tx_valid = 1'b0;
    col = 1'b0;
    repeat (6) @(negedge tx_clk);
    chk("tx_en", 4'h0, 4'(tx_en));
    chk("tx_abort", 4'(col_at >= 0), 4'(aborts));
    if (col_at >= 0) chk("tx_cut", 4'h1, 4'(i_phy.tx_q.size() < len));
    else chk("tx_count", 4'(len), 4'(i_phy.tx_q.size()));
    for (int k = 0; k < len && col_at < 0; k++) chk("txd", 4'h3 + 4'(k), i_phy.tx_q[k]);
  endtask
  // two receive frames with a single idle cycle between them
  task automatic t_rx;
    rx_q.delete();
    ends = 0;
    i_phy.rx_frame(5, 4'h9);
    i_phy.rx_frame(5, 4'h9);
    repeat (4) @(negedge rx_clk);
    chk("rx_count", 4'hA, 4'(rx_q.size()));
    for (int k = 0; k < 10; k++) chk("rxd", 4'h9 + 4'(k % 5), rx_q[k]);
    chk("rx_end", 4'h2, 4'(ends));
  endtask
  initial begin
    errors = 0;
    check_count = 0;
    {nrst, mdc_bit, mo_bit, moe_bit, crs, col, tx_valid, tx_last} = 8'h00;
    tx_nib = 4'h0;
    core(12);
    nrst = 1'b1;
    core(20);
    t_mgmt();
    t_crs();
    t_tx(3, -1);
    t_tx(8, 2);
    t_tx(2, -1);
    t_rx();
    summarize();
  end
endmodule
`default_nettype wire
